//--- logic/sfa_pkg.sv
// constants and carrier types of the serial flash array access block
`default_nettype none
package sfa_pkg;

	// array geometry
	localparam int SECTORS       = 2048;
	localparam int SECTOR_BYTES  = 536;
	localparam int SEC_W         = 11;
	localparam int BYTE_W        = 10;
	localparam int ARR_AW        = 21;
	localparam int ARRAY_BYTES   = SECTORS * SECTOR_BYTES;
	localparam int BLOCK_SHIFT   = 7;
	localparam int BLOCK_LAST    = 15;

	// timing
	localparam int CLK_FREQ_KHZ    = 100000;
	localparam int SCK_MAX_5V_KHZ  = 16000;
	localparam int SCK_MAX_3V_KHZ  = 8000;
	localparam int PROG_TIME_MS    = 5;
	localparam int PROG_CYCLES     = PROG_TIME_MS * CLK_FREQ_KHZ;
	localparam int MIN_PROG_CYCLES = 2 * SECTOR_BYTES + 2;

	// configuration field positions
	localparam int CFG_PIN_LSB  = 0;
	localparam int CFG_EDGE_BIT = 2;
	localparam int CFG_DIR_BIT  = 3;
	localparam int CFG_WR_LSB   = 4;
	localparam int CFG_AF_BIT   = 8;
	localparam logic [8:0] CFG_FACTORY = 9'h009;

	// multi-function pin modes
	localparam logic [1:0] PIN_HOLD = 2'h0;
	localparam logic [1:0] PIN_NC   = 2'h1;
	localparam logic [1:0] PIN_RDY  = 2'h2;

	// opcodes
	localparam logic [7:0] OP_READ_SECTOR = 8'h52;
	localparam logic [7:0] OP_READ_SRAM   = 8'h53;
	localparam logic [7:0] OP_WRITE_SRAM  = 8'h82;
	localparam logic [7:0] OP_WRITE_SECT  = 8'h85;
	localparam logic [7:0] OP_SRAM_TO_SEC = 8'h88;
	localparam logic [7:0] OP_READ_STATUS = 8'hd7;

	// status byte bits
	localparam int STS_READY = 0;
	localparam int STS_FAULT = 1;

	localparam logic [7:0] ERASED_BYTE = 8'hff;

	typedef struct packed {
		logic       alt_osc;
		logic [3:0] wr_range;
		logic       wr_dir;
		logic       read_edge_select;
		logic [1:0] pin_mode;
	} sfa_cfg_t;

endpackage : sfa_pkg
`default_nettype wire

//--- logic/sfa_prog_timer.sv
// sector programming busy timer on the system clock
`timescale 1ns/100ps
`default_nettype none
module sfa_prog_timer #(
	parameter int unsigned CYCLES = sfa_pkg::PROG_CYCLES
) (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic start_i,
	output logic      done_o
);
	import sfa_pkg::*;

	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	typedef struct packed {
		logic          run;
		logic [CW-1:0] cnt;
	} sfa_tmr_t;

	sfa_tmr_t t_q;
	sfa_tmr_t t_d;

	generate
		if (CYCLES < 2) begin : g_chk
			$error("timer needs at least two cycles");
		end
	endgenerate

	always_comb begin
		t_d = t_q;
		if (start_i) begin
			t_d.run = 1'b1;
			t_d.cnt = '0;
		end else if (t_q.run) begin
			if (t_q.cnt == LAST) begin
				t_d.run = 1'b0;
			end else begin
				t_d.cnt = t_q.cnt + CW'(1);
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			t_q <= '0;
		end else begin
			t_q <= t_d;
		end
	end

	assign done_o = t_q.run && (t_q.cnt == LAST);

endmodule : sfa_prog_timer
`default_nettype wire

//--- logic/sfa_flash_core.sv
// serial front end, sram and array access of the serial flash
// Summary of operation
// - serial input command and data bits sampled on rising clock.
// - read data leaves on falling edge, or rising when edge select set.
// - serial clock at most 16 MHz (5 V) or 8 MHz (3 V).
// - serial output floats while deselected or while hold is low.
// - chip select low selects; high means deselected and inactive.
// - after power-up, commands ignored until one chip select rising edge.
// - deselect enters standby, but only after any programming completes.
// - write protect pin low blocks writes to every sector.
// - write protect high allows writes outside the protected range.
// - multi-function pin is unconnected, ready/busy output or hold input.
// - array holds 2048 sectors of 536 individually addressable bytes.
// - sector read starts at addressed byte; any run length allowed.
// - sectors are written only from the sram contents.
// - busy for the programming time; array refuses access meanwhile.
// - ready/busy shown in sector read responses, status byte and pin.
// - sram stays readable and writable while the array is busy.
// - addressed sector is erased automatically at start of each write.
// - read edge select is config bit 2; zero falling, one rising.
// - writes to a sector inside protected range are ignored and flagged in the status fault bit.
`timescale 1ns/100ps
`default_nettype none
module sfa_flash_core #(
	parameter int unsigned PROG_CYCLES = sfa_pkg::PROG_CYCLES
) (
	input  wire logic             CLOCK_I,
	input  wire logic             RESETN_I,
	input  wire logic             SCK_I,
	input  wire logic             CS_N_I,
	input  wire logic             SI_I,
	output logic                  SO_O,
	output logic                  SO_OE_O,
	input  wire logic             WP_N_I,
	input  wire logic             MFP_I,
	output logic                  MFP_O,
	output logic                  MFP_OE_O,
	input  wire sfa_pkg::sfa_cfg_t CONFIG_I,
	output logic                  ARRAY_BUSY_O,
	output logic                  STANDBY_O,
	output logic                  UNLOCKED_O,
	output logic                  PROTECT_HIT_O
);
	import sfa_pkg::*;

	typedef enum logic [1:0] {F_CMD, F_ADDR, F_DATA, F_SKIP} sfa_fst_t;
	typedef enum logic [1:0] {C_IDLE, C_ERASE, C_COPY, C_WAIT} sfa_cst_t;

	// frame state, cleared whenever the device is deselected
	typedef struct packed {
		sfa_fst_t          st;
		logic [2:0]        bitc;
		logic [6:0]        sh;
		logic [7:0]        op;
		logic [1:0]        abyte;
		logic [SEC_W-1:0]  sector;
		logic [BYTE_W-1:0] ptr;
		logic [7:0]        tx;
		logic              so_rise;
	} sfa_frame_t;

	// link-side state that must survive across frames
	typedef struct packed {
		logic             busy_m;
		logic             busy_s;
		logic             unl_m;
		logic             unl_s;
		logic             flt_m;
		logic             flt_s;
		logic             edge_m;
		logic             edge_s;
		logic             req_tog;
		logic [SEC_W-1:0] req_sector;
	} sfa_link_t;

	typedef struct packed {
		logic              cs_m;
		logic              cs_s;
		logic              cs_prev;
		logic              tog_m;
		logic              tog_s;
		logic              tog_ack;
		logic              wp_m;
		logic              wp_s;
		logic              hold_m;
		logic              hold_s;
		sfa_cfg_t          cfg_m;
		sfa_cfg_t          cfg_s;
		logic              unlocked;
		logic              pend;
		logic              busy;
		logic              fault;
		sfa_cst_t          st;
		logic [BYTE_W-1:0] idx;
		logic [SEC_W-1:0]  sector;
	} sfa_core_t;

	localparam logic [BYTE_W-1:0] LAST_BYTE = BYTE_W'(SECTOR_BYTES - 1);

	generate
		if (CLK_FREQ_KHZ < 4 * SCK_MAX_5V_KHZ) begin : g_rate
			$error("system clock too slow for the serial clock");
		end
		if (PROG_CYCLES < MIN_PROG_CYCLES) begin : g_prog
			$error("programming time shorter than erase and copy");
		end
	endgenerate

	sfa_frame_t f_q;
	sfa_frame_t f_d;
	sfa_link_t  l_q;
	sfa_link_t  l_d;
	sfa_core_t  c_q;
	sfa_core_t  c_d;
	logic       so_fall_q;

	logic [7:0] sram [SECTOR_BYTES];
	logic [7:0] flash [ARRAY_BYTES];

	logic              frame_rst_n;
	logic [7:0]        byte_in;
	logic              sram_we;
	logic              req_fire;
	logic [7:0]        status_b;
	logic [7:0]        sector_byte;
	logic [BYTE_W-1:0] addr_ptr;
	logic              arr_we;
	logic [7:0]        arr_wd;
	logic [ARR_AW-1:0] arr_wa;
	logic              tog_edge;
	logic              prog_start;
	logic              prog_done;
	logic              hold_active;

	function automatic logic [ARR_AW-1:0] arr_index(
		input logic [SEC_W-1:0]  sec,
		input logic [BYTE_W-1:0] ptr
	);
		arr_index = ARR_AW'(sec * SECTOR_BYTES + ptr);
	endfunction : arr_index

	// wraps at the sector end so long runs never leave the sector
	function automatic logic [BYTE_W-1:0] next_ptr(
		input logic [BYTE_W-1:0] ptr
	);
		next_ptr = (ptr >= LAST_BYTE) ? '0 : ptr + BYTE_W'(1);
	endfunction : next_ptr

	function automatic logic in_range(
		input logic [SEC_W-1:0] sec,
		input sfa_cfg_t         cfg
	);
		logic [3:0] blk;
		blk = sec[SEC_W-1:BLOCK_SHIFT];
		if (cfg.wr_dir) begin
			blk = 4'(BLOCK_LAST) - blk;
		end
		in_range = blk < cfg.wr_range;
	endfunction : in_range

	assign frame_rst_n = RESETN_I & ~CS_N_I;

	// ready and fault flags in the status byte
	always_comb begin
		status_b = '0;
		status_b[STS_READY] = ~l_q.busy_s;
		status_b[STS_FAULT] = l_q.flt_s;
	end

	// array reads refused while busy
	// the array is static when idle, so the link may read it directly
	assign sector_byte = l_q.busy_s ? ERASED_BYTE
		: flash[arr_index(f_q.sector, f_q.ptr)];

	always_comb begin
		f_d      = f_q;
		sram_we  = 1'b0;
		req_fire = 1'b0;
		// shift in on the rising edge
		byte_in  = {f_q.sh, SI_I};
		addr_ptr = {f_q.ptr[BYTE_W-1:8], byte_in};
		if (addr_ptr > LAST_BYTE) begin
			addr_ptr = '0;
		end
		f_d.sh   = byte_in[6:0];
		f_d.bitc = f_q.bitc + 3'h1;
		if (f_q.bitc == 3'h7) begin
			case (f_q.st)
				F_CMD: begin
					f_d.op    = byte_in;
					f_d.abyte = '0;
					if (!l_q.unl_s) begin
						f_d.st = F_SKIP;
					end else if (byte_in == OP_READ_STATUS) begin
						f_d.st = F_DATA;
						f_d.tx = status_b;
					end else if (byte_in == OP_READ_SECTOR
						|| byte_in == OP_READ_SRAM
						|| byte_in == OP_WRITE_SRAM
						|| byte_in == OP_WRITE_SECT
						|| byte_in == OP_SRAM_TO_SEC) begin
						f_d.st = F_ADDR;
					end else begin
						f_d.st = F_SKIP;
					end
				end
				F_ADDR: begin
					f_d.abyte = f_q.abyte + 2'h1;
					case (f_q.abyte)
						2'h0: f_d.sector[SEC_W-1:8] = byte_in[SEC_W-9:0];
						2'h1: f_d.sector[7:0] = byte_in;
						2'h2: f_d.ptr[BYTE_W-1:8] = byte_in[BYTE_W-9:0];
						default: begin
							f_d.ptr = addr_ptr;
							f_d.st  = F_DATA;
							case (f_q.op)
								OP_READ_SECTOR: f_d.tx = status_b;
								OP_READ_SRAM: begin
									f_d.tx  = sram[addr_ptr];
									f_d.ptr = next_ptr(addr_ptr);
								end
								OP_WRITE_SECT: req_fire = 1'b1;
								OP_SRAM_TO_SEC: begin
									req_fire = 1'b1;
									f_d.st   = F_SKIP;
								end
								default: f_d.tx = '0;
							endcase
						end
					endcase
				end
				F_DATA: begin
					case (f_q.op)
						// sram never waits on the array
						OP_WRITE_SRAM, OP_WRITE_SECT: begin
							sram_we = 1'b1;
							f_d.ptr = next_ptr(f_q.ptr);
						end
						OP_READ_SECTOR: begin
							f_d.tx  = sector_byte;
							f_d.ptr = next_ptr(f_q.ptr);
						end
						OP_READ_SRAM: begin
							f_d.tx  = sram[f_q.ptr];
							f_d.ptr = next_ptr(f_q.ptr);
						end
						OP_READ_STATUS: f_d.tx = status_b;
						default: f_d.tx = '0;
					endcase
				end
				default: f_d.st = F_SKIP;
			endcase
		end
		f_d.so_rise = f_d.tx[~f_d.bitc];
	end

	always_ff @(posedge SCK_I or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			f_q <= '0;
		end else begin
			f_q <= f_d;
		end
	end

	// default output changes on the falling edge
	always_ff @(negedge SCK_I or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			so_fall_q <= 1'b0;
		end else begin
			so_fall_q <= f_q.tx[~f_q.bitc];
		end
	end

	always_ff @(posedge SCK_I) begin
		if (sram_we) begin
			sram[f_q.ptr] <= byte_in;
		end
	end

	always_comb begin
		l_d        = l_q;
		l_d.busy_m = c_q.busy;
		l_d.busy_s = l_q.busy_m;
		l_d.unl_m  = c_q.unlocked;
		l_d.unl_s  = l_q.unl_m;
		l_d.flt_m  = c_q.fault;
		l_d.flt_s  = l_q.flt_m;
		// edge select from config bit 2
		l_d.edge_m = CONFIG_I.read_edge_select;
		l_d.edge_s = l_q.edge_m;
		if (req_fire) begin
			l_d.req_tog    = ~l_q.req_tog;
			l_d.req_sector = f_q.sector;
		end
	end

	// the sector number stays put until the next request, which the
	// core has long taken by then
	always_ff @(posedge SCK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			l_q <= '0;
		end else begin
			l_q <= l_d;
		end
	end

	assign SO_O = l_q.edge_s ? f_q.so_rise : so_fall_q;

	sfa_prog_timer #(
		.CYCLES  (PROG_CYCLES)
	) u_timer (
		.clk_i   (CLOCK_I),
		.rst_n_i (RESETN_I),
		.start_i (prog_start),
		.done_o  (prog_done)
	);

	assign tog_edge = c_q.tog_s ^ c_q.tog_ack;
	assign arr_wa   = arr_index(c_q.sector, c_q.idx);

	always_comb begin
		c_d         = c_q;
		arr_we      = 1'b0;
		arr_wd      = ERASED_BYTE;
		prog_start  = 1'b0;
		c_d.cs_m    = CS_N_I;
		c_d.cs_s    = c_q.cs_m;
		c_d.cs_prev = c_q.cs_s;
		c_d.tog_m   = l_q.req_tog;
		c_d.tog_s   = c_q.tog_m;
		c_d.tog_ack = c_q.tog_s;
		c_d.wp_m    = WP_N_I;
		c_d.wp_s    = c_q.wp_m;
		c_d.hold_m  = MFP_I;
		c_d.hold_s  = c_q.hold_m;
		c_d.cfg_m   = CONFIG_I;
		c_d.cfg_s   = c_q.cfg_m;
		if (c_q.cs_s && !c_q.cs_prev) begin
			c_d.unlocked = 1'b1;
		end
		case (c_q.st)
			C_IDLE: begin
				if (c_q.pend && c_q.cs_s) begin
					c_d.pend   = 1'b0;
					c_d.sector = l_q.req_sector;
					if (!c_q.wp_s || in_range(l_q.req_sector, c_q.cfg_s)) begin
						c_d.fault = 1'b1;
					end else begin
						c_d.fault  = 1'b0;
						c_d.busy   = 1'b1;
						c_d.idx    = '0;
						c_d.st     = C_ERASE;
						prog_start = 1'b1;
					end
				end
			end
			C_ERASE: begin
				arr_we = 1'b1;
				if (c_q.idx == LAST_BYTE) begin
					c_d.idx = '0;
					c_d.st  = C_COPY;
				end else begin
					c_d.idx = c_q.idx + BYTE_W'(1);
				end
			end
			C_COPY: begin
				arr_we = 1'b1;
				arr_wd = sram[c_q.idx];
				if (c_q.idx == LAST_BYTE) begin
					c_d.st = C_WAIT;
				end else begin
					c_d.idx = c_q.idx + BYTE_W'(1);
				end
			end
			C_WAIT: begin
				if (prog_done) begin
					c_d.busy = 1'b0;
					c_d.st   = C_IDLE;
				end
			end
			default: c_d.st = C_IDLE;
		endcase
		// writes refused while busy
		// after the take, so a fresh request is never lost
		if (tog_edge && c_q.unlocked && !c_q.busy) begin
			c_d.pend = 1'b1;
		end
	end

	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			c_q         <= '0;
			c_q.cs_m    <= 1'b1;
			c_q.cs_s    <= 1'b1;
			c_q.cs_prev <= 1'b1;
			c_q.hold_m  <= 1'b1;
			c_q.hold_s  <= 1'b1;
			c_q.cfg_m   <= CFG_FACTORY;
			c_q.cfg_s   <= CFG_FACTORY;
		end else begin
			c_q <= c_d;
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (arr_we) begin
			flash[arr_wa] <= arr_wd;
		end
	end

	assign hold_active = (c_q.cfg_s.pin_mode == PIN_HOLD) && !c_q.hold_s;

	assign SO_OE_O = ~c_q.cs_s & ~hold_active;

	// ready/busy drive only in that mode
	assign MFP_OE_O = (c_q.cfg_s.pin_mode == PIN_RDY);
	assign MFP_O    = (c_q.cfg_s.pin_mode == PIN_RDY) & ~c_q.busy;

	assign ARRAY_BUSY_O  = c_q.busy;
	assign STANDBY_O     = c_q.cs_s & ~c_q.busy;
	assign UNLOCKED_O    = c_q.unlocked;
	assign PROTECT_HIT_O = c_q.fault;

endmodule : sfa_flash_core
`default_nettype wire

//--- test/sfa_flash_core_properties.sv
// port assertions of the serial flash core
`timescale 1ns/100ps
`default_nettype none
module sfa_core_chk #(
	parameter int unsigned PROG_CYCLES = 1200
) (
	input wire logic              CLOCK_I,
	input wire logic              RESETN_I,
	input wire logic              SCK_I,
	input wire logic              CS_N_I,
	input wire logic              SI_I,
	input wire logic              SO_O,
	input wire logic              SO_OE_O,
	input wire logic              WP_N_I,
	input wire logic              MFP_I,
	input wire logic              MFP_O,
	input wire logic              MFP_OE_O,
	input wire sfa_pkg::sfa_cfg_t CONFIG_I,
	input wire logic              ARRAY_BUSY_O,
	input wire logic              STANDBY_O,
	input wire logic              UNLOCKED_O,
	input wire logic              PROTECT_HIT_O
);
	import sfa_pkg::*;

	logic [31:0] cnt_q;

	// busy length counted here, too long for a repetition
	// wide enough for the full programming time
	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I)
			cnt_q <= 32'h0;
		else
			cnt_q <= ARRAY_BUSY_O ? cnt_q + 32'h1 : 32'h0;
	end

	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (!RESETN_I);

	property p_so_cs;
		CS_N_I [*5] |-> !SO_OE_O;
	endproperty
	a_so_cs: assert property (p_so_cs) else $error("so driven");
	property p_so_hold;
		(CONFIG_I.pin_mode == PIN_HOLD && !MFP_I) [*6] |-> !SO_OE_O;
	endproperty
	a_so_hold: assert property (p_so_hold) else $error("so held");
	property p_pin_dir;
		$stable(CONFIG_I) [*6] |-> MFP_OE_O == (CONFIG_I.pin_mode == PIN_RDY);
	endproperty
	a_pin_dir: assert property (p_pin_dir) else $error("pin dir");
	property p_rdy_pin;
		MFP_OE_O && $stable(MFP_OE_O) && $stable(ARRAY_BUSY_O)
			|-> MFP_O == !ARRAY_BUSY_O;
	endproperty
	a_rdy_pin: assert property (p_rdy_pin) else $error("rdy pin");
	property p_busy_len;
		$fell(ARRAY_BUSY_O) |-> cnt_q == PROG_CYCLES;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy len");
	property p_prog_cs;
		$rose(ARRAY_BUSY_O) |-> $past(CS_N_I) && $past(CS_N_I, 3);
	endproperty
	a_prog_cs: assert property (p_prog_cs) else $error("prog sel");
	property p_wp;
		$rose(ARRAY_BUSY_O) |-> $past(WP_N_I, 3) && !PROTECT_HIT_O;
	endproperty
	a_wp: assert property (p_wp) else $error("prog protected");
	property p_lock;
		!UNLOCKED_O |-> !ARRAY_BUSY_O && !PROTECT_HIT_O;
	endproperty
	a_lock: assert property (p_lock) else $error("prog locked");
	property p_stby;
		CS_N_I [*4] |-> STANDBY_O == !ARRAY_BUSY_O;
	endproperty
	a_stby: assert property (p_stby) else $error("standby busy");
endmodule : sfa_core_chk

bind sfa_flash_core sfa_core_chk #(.PROG_CYCLES(PROG_CYCLES)) i_sfa_core_chk (
	.CLOCK_I(CLOCK_I), .RESETN_I(RESETN_I), .SCK_I(SCK_I), .CS_N_I(CS_N_I),
	.SI_I(SI_I), .SO_O(SO_O), .SO_OE_O(SO_OE_O), .WP_N_I(WP_N_I),
	.MFP_I(MFP_I), .MFP_O(MFP_O), .MFP_OE_O(MFP_OE_O), .CONFIG_I(CONFIG_I),
	.ARRAY_BUSY_O(ARRAY_BUSY_O), .STANDBY_O(STANDBY_O),
	.UNLOCKED_O(UNLOCKED_O), .PROTECT_HIT_O(PROTECT_HIT_O)
);
`default_nettype wire

//--- test/sfa_host_model.sv
// serial bus master standing in for the host controller
`timescale 1ns/100ps
`default_nettype none
module sfa_host_model (
	output logic      sck_o,
	output logic      cs_n_o,
	output logic      si_o,
	input  wire logic so_i,
	input  wire logic so_oe_i,
	input  wire logic redge_i
);
	logic [7:0] rx_q[$];
	logic       seen;

	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
		seen = 1'b0;
	end

	// floating output reads as the inverse of the last bit
	task automatic smp(output logic b);
		seen = so_oe_i ? so_i : ~seen;
		b = seen;
	endtask : smp

	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			if (redge_i)
				smp(rx[i]);
			sck_o = 1'b0;
			si_o = tx[i];
			#40;
			if (!redge_i)
				smp(rx[i]);
			sck_o = 1'b1;
			#40;
		end
	endtask : xfer

	task automatic frame(input logic [7:0] tx[$]);
		logic [7:0] r;
		rx_q = {};
		#3.3;
		cs_n_o = 1'b0;
		#40;
		foreach (tx[k]) begin
			xfer(tx[k], r);
			rx_q.push_back(r);
		end
		sck_o = 1'b0;
		si_o = ~si_o;
		#40;
		cs_n_o = 1'b1;
		#300;
	endtask : frame
endmodule : sfa_host_model
`default_nettype wire

//--- test/sfa_flash_core_tb.sv
// self-checking bench of the serial flash core
`timescale 1ns/100ps
`default_nettype none
module sfa_flash_core_tb;
	import sfa_pkg::*;
	// short programming time keeps the run brief
	localparam int PC = 3000;
	logic            clk;
	logic            rst_n;
	logic            wp_n;
	logic            mfp;
	sfa_cfg_t        cfg;
	wire logic       sck, cs_n, si, so, so_oe, mfp_o, mfp_oe;
	wire logic       busy, stby, unl, hit;
	wire logic       mfp_w = mfp_oe ? mfp_o : mfp;
	wire logic [7:0] flg = {mfp_oe, mfp_o, 2'h0, busy, stby, unl, hit};
	logic [7:0]      sram[SECTOR_BYTES];
	logic [7:0]      fl[int];
	logic [7:0]      tx[$];
	int              num_errors;
	int              tests_run;
	int              s;
	logic [7:0]      hb;
	int              tsec[5] = '{100, 127, 128, 1792, 1791};
	int              trng[5] = '{0, 1, 1, 2, 2};
	logic [4:0]      twp = 5'b11110;
	logic [4:0]      tdir = 5'b11001;
	logic [4:0]      tok = 5'b10100;

	sfa_flash_core #(.PROG_CYCLES(PC)) i_sfa_flash_core (
		.CLOCK_I(clk), .RESETN_I(rst_n), .SCK_I(sck), .CS_N_I(cs_n),
		.SI_I(si), .SO_O(so), .SO_OE_O(so_oe), .WP_N_I(wp_n),
		.MFP_I(mfp_w), .MFP_O(mfp_o), .MFP_OE_O(mfp_oe), .CONFIG_I(cfg),
		.ARRAY_BUSY_O(busy), .STANDBY_O(stby), .UNLOCKED_O(unl),
		.PROTECT_HIT_O(hit)
	);
	sfa_host_model i_sfa_host_model (
		.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so),
		.so_oe_i(so_oe), .redge_i(cfg.read_edge_select)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic summarize();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize

	task automatic wait_busy(input logic v);
		int n;
		n = 0;
		while (busy !== v && n < 4000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n == 4000) begin
			num_errors++;
			summarize();
		end
	endtask : wait_busy

	task automatic run(input logic [7:0] op, input int sec, p, n);
		tx = {op, 8'(sec >> 8), 8'(sec), 8'(p >> 8), 8'(p)};
		for (int i = 0; i < n; i++) begin
			tx.push_back(8'($urandom));
			if (op == OP_WRITE_SRAM || op == OP_WRITE_SECT)
				sram[(p + i) % SECTOR_BYTES] = tx[5 + i];
		end
		i_sfa_host_model.frame(tx);
	endtask : run

	task automatic st(input logic [1:0] e);
		run(OP_READ_STATUS, 0, 0, 0);
		chk(i_sfa_host_model.rx_q[4] & 8'h03, {6'h0, e});
	endtask : st

	task automatic rd(input logic [7:0] op, input int sec, p, n,
		input logic [1:0] e);
		int         o;
		logic [7:0] x;
		o = (op == OP_READ_SECTOR) ? 6 : 5;
		run(op, sec, p, n + o - 5);
		if (o == 6)
			chk(i_sfa_host_model.rx_q[5] & 8'h03, {6'h0, e});
		for (int i = 0; i < n; i++) begin
			if (o == 5)
				x = sram[(p + i) % SECTOR_BYTES];
			else if (!e[0])
				x = ERASED_BYTE;
			else
				x = fl[sec * SECTOR_BYTES + (p + i) % SECTOR_BYTES];
			chk(i_sfa_host_model.rx_q[o + i], x);
		end
	endtask : rd

	task automatic prog(input int sec);
		wait_busy(1'b1);
		chk(flg, 8'h8a);
		st(2'h0);
		rd(OP_READ_SRAM, 0, 530, 8, 2'h0);
		rd(OP_READ_SECTOR, sec, 0, 2, 2'h0);
		for (int i = 0; i < SECTOR_BYTES; i++)
			fl[sec * SECTOR_BYTES + i] = sram[i];
		wait_busy(1'b0);
		chk(flg, 8'hc6);
		rd(OP_READ_SECTOR, sec, 533, 6, 2'h1);
	endtask : prog

	initial begin
		rst_n = 1'b0;
		wp_n = 1'b1;
		mfp = 1'b1;
		cfg = CFG_FACTORY;
		num_errors = 0;
		tests_run = 0;
		void'($urandom(70));
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		#1 chk(flg & 8'h8f, 8'h04);
		run(OP_SRAM_TO_SEC, 5, 0, 0);
		chk(flg & 8'h8f, 8'h06);
		@(posedge clk);
		cfg.pin_mode <= PIN_RDY;
		run(OP_WRITE_SRAM, 0, 0, SECTOR_BYTES);
		rd(OP_READ_SRAM, 0, 530, 12, 2'h1);
		s = $urandom_range(2047, 0);
		run(OP_WRITE_SECT, s, 533, 5);
		prog(s);
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			wp_n <= twp[i];
			cfg.wr_range <= 4'(trng[i]);
			cfg.wr_dir <= tdir[i];
			repeat (4) @(posedge clk);
			run(OP_SRAM_TO_SEC, tsec[i], 0, 0);
			chk({7'h0, hit}, {7'h0, ~tok[i]});
			if (tok[i])
				prog(tsec[i]);
			else
				st(2'h3 & {1'b1, 1'b1});
		end
		@(posedge clk);
		cfg.read_edge_select <= 1'b1;
		rd(OP_READ_SRAM, 0, 7, 8, 2'h1);
		st(2'h1);
		@(posedge clk);
		cfg.pin_mode <= PIN_HOLD;
		mfp <= 1'b0;
		run(OP_READ_STATUS, 0, 0, 0);
		// held output floats, so the host sees alternating bits
		hb = i_sfa_host_model.rx_q[4];
		chk(hb ^ {hb[0], hb[7:1]}, 8'hff);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		#1 chk(flg & 8'h0f, 8'h04);
		summarize();
	end
endmodule : sfa_flash_core_tb
`default_nettype wire
